// ### rtl/egress_sel_defs.svh
// constants of the link egress event selector: register map, field layout,
// reset values, event codes, unit-mask bits, per-cycle caps and flit timing.
// assumes it is included once per compile unit through its guard.
`ifndef EGRESS_SEL_DEFS_SVH
`define EGRESS_SEL_DEFS_SVH

// register byte offsets on the avalon slave
`define OFS_CTL_BASE 6'h00
`define OFS_CNT_BASE 6'h10
`define OFS_STATUS 6'h30
// counter control word layout
`define CTL_EV_LSB 0
`define CTL_UMASK_LSB 8
`define CTL_RST_BIT 17
`define CTL_EXT_BIT 21
`define CTL_EN_BIT 22
`define CTL_RW_MASK 32'h0060_FFFF
`define CTL_RESET 32'h0000_0000
`define CNT_RESET 48'h0000_0000_0000
// event codes, all of them need the extended select bit
`define EV_SENT_FLITS 8'h01
`define EV_BUF_ALLOC 8'h04
`define EV_BUF_FILL 8'h07
`define EV_CRQ_ACQ 8'h26
`define EV_CRQ_AVAIL 8'h22
`define EV_NDR_ACQ 8'h28
`define EV_NDR_AVAIL 8'h24
`define EV_SNP_ACQ 8'h27
`define EV_SNP_AVAIL 8'h23
`define EV_AKN_ACQ 8'h29
`define EV_AKN_AVAIL 8'h25
`define EV_CRD_ACQ 8'h2a
`define EV_CRD_AVAIL 8'h1f
`define EV_NCB_ACQ 8'h2b
`define EV_NCB_AVAIL 8'h20
`define EV_NCS_ACQ 8'h2c
`define EV_NCS_AVAIL 8'h21
`define EV_POOL_RET 8'h1c
`define EV_POOL_PEND 8'h1b
// unit-mask bits
`define UM_NDR_LOCAL 0
`define UM_NDR_RTHRU 1
`define UM_NCB_PAYLOAD 2
`define UM_NCB_OVERHEAD 3
`define UM_NCS 4
`define UM_VN0 0
`define UM_VN1 1
`define UM_VNSHR 2
// per-cycle increment caps
`define CAP_FLITS 8'h02
`define CAP_CRQ 8'h1C
`define CAP_SNP 8'h1C
`define CAP_NDR 8'h08
`define CAP_AKN 8'h06
`define CAP_CRD 8'h08
`define CAP_NC 8'h02
`define CAP_POOL 8'h80
// flit framing: 80-bit flit, 20-bit transfers full width, 10-bit half width
`define FLIT_BITS 80
`define XFER_BITS_FULL 20
`define XFER_BITS_HALF 10
`define FILL_MAX 7'h40

`endif

// ### rtl/egress_sel_pkg.sv
// types shared by the link egress event selector files.
// assumes egress_sel_defs.svh carries all numeric constants.
package egress_sel_pkg;

  // class of the flit that a transfer lane is carrying
  typedef enum logic [2:0] {
    fc_none = 3'b000,
    fc_ndr_local = 3'b001,
    fc_ndr_rthru = 3'b010,
    fc_ncb_payload = 3'b011,
    fc_ncb_overhead = 3'b100,
    fc_ncs = 3'b101,
    fc_other = 3'b110
  } flit_class_t;

  // flits completed this cycle, per class, 0 to 2 each
  typedef struct packed {
    logic [1:0] ndr_local;
    logic [1:0] ndr_rthru;
    logic [1:0] ncb_payload;
    logic [1:0] ncb_overhead;
    logic [1:0] noncoherent_standard_class;
  } sent_flits_t;

  // credit acquire pulses; two-bit fields are {vn1, vn0}, crd is {shr, vn1, vn0}
  typedef struct packed {
    logic [1:0] crq;
    logic [1:0] snoop_class;
    logic [1:0] nondata_response_class;
    logic akn;
    logic [2:0] crd;
    logic [1:0] noncoherent_bypass_class;
    logic [1:0] noncoherent_standard_class;
    logic pool_ret;
  } credit_pulse_t;

  // credits available this cycle, per class and virtual network
  typedef struct packed {
    logic [4:0] crq_vn0;
    logic [4:0] crq_vn1;
    logic [4:0] snp_vn0;
    logic [4:0] snp_vn1;
    logic [3:0] ndr_vn0;
    logic [3:0] ndr_vn1;
    logic [2:0] akn;
    logic [3:0] crd_vn0;
    logic [3:0] crd_vn1;
    logic [3:0] crd_shr;
    logic [1:0] ncb_vn0;
    logic [1:0] ncb_vn1;
    logic [1:0] ncs_vn0;
    logic [1:0] ncs_vn1;
    logic [7:0] pool_pend;
  } credit_level_t;

  // everything a counter can select from in one cycle
  typedef struct packed {
    sent_flits_t flits;
    logic alloc;
    logic [6:0] fill;
    credit_pulse_t pulse;
    credit_level_t level;
  } event_sample_t;

  // decoded counter control
  typedef struct packed {
    logic en;
    logic ext;
    logic [7:0] umask;
    logic [7:0] ev_sel;
  } counter_ctl_t;

endpackage

// ### rtl/flit_framer.sv
// one transfer lane: gathers link transfers into whole flits.
// assumes transfers arrive from logic on ref_clk, one per cycle at most.
`timescale 1ns/100ps
`include "egress_sel_defs.svh"
module flit_framer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // transfer lane
  input wire logic xfer_valid,
  input wire egress_sel_pkg::flit_class_t xfer_class,
  input wire logic half_width_state,
  // completed flit, one-cycle pulse
  output logic flit_done,
  output egress_sel_pkg::flit_class_t flit_class
);

  localparam logic [2:0] LAST_FULL = 3'((`FLIT_BITS / `XFER_BITS_FULL) - 1);
  localparam logic [2:0] LAST_HALF = 3'((`FLIT_BITS / `XFER_BITS_HALF) - 1);

  logic [2:0] beat_ff; // transfers seen of the current flit
  egress_sel_pkg::flit_class_t cls_ff; // class caught on the first transfer
  wire [2:0] last_beat = half_width_state ? LAST_HALF : LAST_FULL;
  wire at_last = xfer_valid && (beat_ff >= last_beat);
  wire egress_sel_pkg::flit_class_t cur_cls = (beat_ff == 3'h0) ? xfer_class : cls_ff;

  // beat counter; a width change mid-flit ends it at the new length
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      beat_ff <= 3'h0;
      cls_ff <= egress_sel_pkg::fc_none;
      flit_done <= 1'b0;
      flit_class <= egress_sel_pkg::fc_none;
    end else begin
      beat_ff <= at_last ? 3'h0 : (xfer_valid ? beat_ff + 3'h1 : beat_ff);
      cls_ff <= (xfer_valid && beat_ff == 3'h0) ? xfer_class : cls_ff;
      flit_done <= at_last;
      flit_class <= at_last ? cur_cls : egress_sel_pkg::fc_none;
    end
  end

endmodule

// ### rtl/event_decoder.sv
// per-counter event selection: event code plus unit mask to an increment.
// assumes the sample is stable within the cycle; pure combinational logic.
`timescale 1ns/100ps
`include "egress_sel_defs.svh"
module event_decoder (
  // selection
  input wire egress_sel_pkg::counter_ctl_t ctl,
  input wire egress_sel_pkg::event_sample_t ev,
  // increment for this cycle
  output logic [7:0] inc
);

  // keep a value only when its mask bit is set
  function automatic logic [7:0] pick(input logic sel, input logic [7:0] v);
    pick = sel ? v : 8'h00;
  endfunction

  // clip a sum to the documented per-cycle maximum
  function automatic logic [7:0] cap(input logic [7:0] v, input logic [7:0] lim);
    cap = (v > lim) ? lim : v;
  endfunction

  wire [7:0] m = ctl.umask;
  wire [7:0] flits = pick(m[`UM_NDR_LOCAL], 8'(ev.flits.ndr_local))
    + pick(m[`UM_NDR_RTHRU], 8'(ev.flits.ndr_rthru))
    + pick(m[`UM_NCB_PAYLOAD], 8'(ev.flits.ncb_payload))
    + pick(m[`UM_NCB_OVERHEAD], 8'(ev.flits.ncb_overhead))
    + pick(m[`UM_NCS], 8'(ev.flits.noncoherent_standard_class));
  wire [7:0] crq_acq = pick(m[`UM_VN0], 8'(ev.pulse.crq[0])) | pick(m[`UM_VN1], 8'(ev.pulse.crq[1]));
  wire [7:0] snp_acq = pick(m[`UM_VN0], 8'(ev.pulse.snoop_class[0])) | pick(m[`UM_VN1], 8'(ev.pulse.snoop_class[1]));
  wire [7:0] ndr_acq = pick(m[`UM_VN0], 8'(ev.pulse.nondata_response_class[0])) | pick(m[`UM_VN1], 8'(ev.pulse.nondata_response_class[1]));
  wire [7:0] crd_acq = pick(m[`UM_VN0], 8'(ev.pulse.crd[0])) | pick(m[`UM_VN1], 8'(ev.pulse.crd[1]))
    | pick(m[`UM_VNSHR], 8'(ev.pulse.crd[2]));
  wire [7:0] ncb_acq = pick(m[`UM_VN0], 8'(ev.pulse.noncoherent_bypass_class[0])) | pick(m[`UM_VN1], 8'(ev.pulse.noncoherent_bypass_class[1]));
  wire [7:0] ncs_acq = pick(m[`UM_VN0], 8'(ev.pulse.noncoherent_standard_class[0])) | pick(m[`UM_VN1], 8'(ev.pulse.noncoherent_standard_class[1]));
  wire [7:0] crq_av = pick(m[`UM_VN0], 8'(ev.level.crq_vn0)) + pick(m[`UM_VN1], 8'(ev.level.crq_vn1));
  wire [7:0] snp_av = pick(m[`UM_VN0], 8'(ev.level.snp_vn0)) + pick(m[`UM_VN1], 8'(ev.level.snp_vn1));
  wire [7:0] ndr_av = pick(m[`UM_VN0], 8'(ev.level.ndr_vn0)) + pick(m[`UM_VN1], 8'(ev.level.ndr_vn1));
  wire [7:0] crd_av = pick(m[`UM_VN0], 8'(ev.level.crd_vn0)) + pick(m[`UM_VN1], 8'(ev.level.crd_vn1))
    + pick(m[`UM_VNSHR], 8'(ev.level.crd_shr));
  wire [7:0] ncb_av = pick(m[`UM_VN0], 8'(ev.level.ncb_vn0)) + pick(m[`UM_VN1], 8'(ev.level.ncb_vn1));
  wire [7:0] ncs_av = pick(m[`UM_VN0], 8'(ev.level.ncs_vn0)) + pick(m[`UM_VN1], 8'(ev.level.ncs_vn1));

  // every event here needs the extended select bit as part of the match
  always_comb begin
    inc = 8'h00;
    if (ctl.en && ctl.ext) begin
      case (ctl.ev_sel)
        `EV_SENT_FLITS: inc = cap(flits, `CAP_FLITS);
        `EV_BUF_ALLOC: inc = 8'(ev.alloc);
        `EV_BUF_FILL: inc = 8'(ev.fill);
        `EV_CRQ_ACQ: inc = crq_acq;
        `EV_CRQ_AVAIL: inc = cap(crq_av, `CAP_CRQ);
        `EV_NDR_ACQ: inc = ndr_acq;
        `EV_NDR_AVAIL: inc = cap(ndr_av, `CAP_NDR);
        `EV_SNP_ACQ: inc = snp_acq;
        `EV_SNP_AVAIL: inc = cap(snp_av, `CAP_SNP);
        `EV_AKN_ACQ: inc = 8'(ev.pulse.akn);
        `EV_AKN_AVAIL: inc = cap(8'(ev.level.akn), `CAP_AKN);
        `EV_CRD_ACQ: inc = crd_acq;
        `EV_CRD_AVAIL: inc = cap(crd_av, `CAP_CRD);
        `EV_NCB_ACQ: inc = ncb_acq;
        `EV_NCB_AVAIL: inc = cap(ncb_av, `CAP_NC);
        `EV_NCS_ACQ: inc = ncs_acq;
        `EV_NCS_AVAIL: inc = cap(ncs_av, `CAP_NC);
        `EV_POOL_RET: inc = 8'(ev.pulse.pool_ret);
        `EV_POOL_PEND: inc = cap(ev.level.pool_pend, `CAP_POOL);
        default: inc = 8'h00;
      endcase
    end
  end

endmodule

// ### rtl/link_egress_event_selector.sv
// link egress event selector: four 48-bit event counters behind an
// avalon-mm slave, fed by flit framing, transmit buffer tracking and
// egress credit observations.
// assumes every event input is produced by logic on ref_clk.
`timescale 1ns/100ps
`include "egress_sel_defs.svh"
// Operation
// - event 01 counts sent flits, two per cycle
// - mask bits 0,1 pick local, route-through responses
// - mask bits 2,3,4 pick bypass payload/overhead, standard
// - flit is four or eight link transfers
// - event 04 counts buffer allocations, one per cycle
// - buffer used in half width, retry, or while it still holds flits
// - event 07 adds buffer fill every cycle
// - event 26 counts request credits acquired per network
// - event 22 adds request credits available, max 28
// - event 28 counts response credits acquired per network
// - event 24 adds response credits available, max 8
// - event 27 counts snoop credits acquired per network
// - event 23 adds snoop credits available, max 28
// - event 29 counts acknowledge-ring response credits acquired
// - event 25 adds acknowledge-ring response credits, max 6
// - event 2a counts data credits, shared network too
// - event 1f adds data credits available, max 8
// - events 2b,20 for bypass class credits
// - events 2c,21 for standard class credits
// - event 1c counts pool credits given back
// - event 1b adds pool credits pending, max 128
module link_egress_event_selector (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // avalon-mm register slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // link transfer lanes, two flits per cycle at most
  input wire logic [1:0] xfer_valid,
  input wire egress_sel_pkg::flit_class_t xfer_class_lane0,
  input wire egress_sel_pkg::flit_class_t xfer_class_lane1,
  input wire logic half_width_state,
  input wire logic link_retry,
  input wire logic buffer_drain,
  // egress credit observations
  input wire egress_sel_pkg::credit_pulse_t credit_pulse,
  input wire egress_sel_pkg::credit_level_t credit_level,
  // transmit path status
  output logic flit_bypassed,
  output logic [6:0] buffer_fill
);

  localparam int NCNT = 4;

  // ---------------------------------------------------------------
  // flit framing, one framer per transfer lane
  // ---------------------------------------------------------------
  logic [1:0] lane_done; // flit completed on a lane this cycle
  egress_sel_pkg::flit_class_t lane_cls [2]; // its class
  egress_sel_pkg::flit_class_t lane_in [2]; // incoming class per lane

  assign lane_in[0] = xfer_class_lane0;
  assign lane_in[1] = xfer_class_lane1;

  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++) begin : g_lane
      flit_framer u_framer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .xfer_valid(xfer_valid[gl]),
        .xfer_class(lane_in[gl]),
        .half_width_state(half_width_state),
        .flit_done(lane_done[gl]),
        .flit_class(lane_cls[gl])
      );
    end
  endgenerate

  // count how many completed lanes carry a given class
  function automatic logic [1:0] class_hits(input logic [1:0] done,
                                            input egress_sel_pkg::flit_class_t c0,
                                            input egress_sel_pkg::flit_class_t c1,
                                            input egress_sel_pkg::flit_class_t want);
    class_hits = 2'((done[0] && c0 == want) ? 1 : 0) + 2'((done[1] && c1 == want) ? 1 : 0);
  endfunction

  // per-class sent flit counts for this cycle
  egress_sel_pkg::sent_flits_t sent;
  assign sent.ndr_local = class_hits(lane_done, lane_cls[0], lane_cls[1], egress_sel_pkg::fc_ndr_local);
  assign sent.ndr_rthru = class_hits(lane_done, lane_cls[0], lane_cls[1], egress_sel_pkg::fc_ndr_rthru);
  assign sent.ncb_payload = class_hits(lane_done, lane_cls[0], lane_cls[1], egress_sel_pkg::fc_ncb_payload);
  assign sent.ncb_overhead = class_hits(lane_done, lane_cls[0], lane_cls[1], egress_sel_pkg::fc_ncb_overhead);
  assign sent.noncoherent_standard_class = class_hits(lane_done, lane_cls[0], lane_cls[1], egress_sel_pkg::fc_ncs);

  // ---------------------------------------------------------------
  // transmit flit buffer tracking
  // ---------------------------------------------------------------
  logic [6:0] fill_ff; // flits held in the transmit buffer
  logic bypass_ff; // a flit went straight to the link
  // once something is queued, later flits queue too so order is kept
  wire use_buffer = half_width_state || link_retry || (fill_ff != 7'h00);
  wire [6:0] n_done = 7'(lane_done[0]) + 7'(lane_done[1]);
  wire [6:0] n_in = use_buffer ? n_done : 7'h00;
  wire drain = buffer_drain && (fill_ff != 7'h00); // drain of an empty buffer is ignored
  wire [6:0] sum_fill = fill_ff + n_in - 7'(drain);
  // counting only: no data is stored here; saturate rather than wrap
  wire [6:0] nxt_fill = (sum_fill > `FILL_MAX) ? `FILL_MAX : sum_fill;
  wire alloc = use_buffer && (n_done != 7'h00); // one per cycle at most
  wire nxt_bypass = !use_buffer && (n_done != 7'h00);

  // buffer fill and bypass pulse
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fill_ff <= 7'h00;
      bypass_ff <= 1'b0;
    end else begin
      fill_ff <= nxt_fill;
      bypass_ff <= nxt_bypass;
    end
  end

  assign flit_bypassed = bypass_ff;
  assign buffer_fill = fill_ff;

  // ---------------------------------------------------------------
  // event sample shared by all counters
  // ---------------------------------------------------------------
  egress_sel_pkg::event_sample_t sample;
  assign sample.flits = sent;
  assign sample.alloc = alloc;
  assign sample.fill = fill_ff;
  assign sample.pulse = credit_pulse;
  assign sample.level = credit_level;

  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  // word index inside a block of four
  wire [1:0] word_idx = avs_address[3:2];
  wire hit_ctl = (avs_address[5:4] == `OFS_CTL_BASE >> 4);
  wire hit_cnt_lo = (avs_address[5:4] == `OFS_CNT_BASE >> 4) && !avs_address[2];
  wire hit_cnt_any = (avs_address[5:4] == 2'h1) || (avs_address[5:4] == 2'h2);
  wire hit_status = (avs_address == `OFS_STATUS);
  // counter number behind a counter word: two words per counter
  wire [1:0] cnt_idx = 2'(({1'b0, avs_address[5:3]} - 4'(`OFS_CNT_BASE >> 3)));
  wire cnt_hi = avs_address[2];
  wire aligned = (avs_address[1:0] == 2'b00);

  logic ack_ff; // one-cycle answer, high while the registered waitrequest is low
  logic wait_ff; // registered waitrequest, so the pin leaves a flop directly
  logic [31:0] rdata_ff; // read data held for the answer cycle
  // a request is answered one cycle after it appears
  wire take = (avs_read || avs_write) && !ack_ff;
  wire wr_now = avs_write && ack_ff; // write lands when waitrequest is seen low

  // merge a write with byte enables into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old_v & ~m) | (new_v & m);
  endfunction

  // ---------------------------------------------------------------
  // counter controls and counters
  // ---------------------------------------------------------------
  logic [31:0] ctl_ff [NCNT]; // stored control words
  logic [47:0] cnt_ff [NCNT]; // event counters
  logic [7:0] inc [NCNT]; // selected increment per counter
  logic [31:0] cnt_word [NCNT]; // counter word chosen by address half

  genvar gc;
  generate
    for (gc = 0; gc < NCNT; gc++) begin : g_cnt
      egress_sel_pkg::counter_ctl_t ctl;
      wire ctl_wr = wr_now && aligned && hit_ctl && (word_idx == 2'(gc));
      wire [31:0] merged = be_merge(ctl_ff[gc], avs_writedata, avs_byteenable);
      // the clear bit is write-only: it acts, never stored
      wire clr = ctl_wr && avs_byteenable[2] && avs_writedata[`CTL_RST_BIT];

      assign ctl.en = ctl_ff[gc][`CTL_EN_BIT];
      assign ctl.ext = ctl_ff[gc][`CTL_EXT_BIT];
      assign ctl.umask = ctl_ff[gc][`CTL_UMASK_LSB +: 8];
      assign ctl.ev_sel = ctl_ff[gc][`CTL_EV_LSB +: 8];
      assign cnt_word[gc] = cnt_hi ? {16'h0000, cnt_ff[gc][47:32]} : cnt_ff[gc][31:0];

      event_decoder u_dec (
        .ctl(ctl),
        .ev(sample),
        .inc(inc[gc])
      );

      // control word: only the documented writable bits are kept
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          ctl_ff[gc] <= `CTL_RESET;
        end else if (ctl_wr) begin
          ctl_ff[gc] <= merged & `CTL_RW_MASK;
        end
      end

      // counter: clear wins over the increment of the same cycle; wraps at 48 bits
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_ff[gc] <= `CNT_RESET;
        end else if (clr) begin
          cnt_ff[gc] <= `CNT_RESET;
        end else begin
          cnt_ff[gc] <= cnt_ff[gc] + 48'(inc[gc]);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  // status word: buffer fill, link state, retry, buffer in use
  wire [31:0] status_word = {22'h00_0000, use_buffer, link_retry, half_width_state, 7'(fill_ff)};
  wire [31:0] nxt_rdata = !aligned ? 32'h0000_0000 :
                          hit_ctl ? ctl_ff[word_idx] :
                          hit_cnt_any ? cnt_word[cnt_idx] :
                          hit_status ? status_word :
                          32'h0000_0000; // unmapped reads as zero

  // bus answer: waitrequest drops for exactly one cycle per request
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= take;
      wait_ff <= !take;
      rdata_ff <= (take && avs_read) ? nxt_rdata : rdata_ff;
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;

  // hit_cnt_lo is kept for the counter block decode check of the low word
  wire unused_lo = hit_cnt_lo;

endmodule

// ### bench/egress_sel_properties.sv
// checker: bus handshake and transmit buffer relations at the selector ports
// assumes one clock domain; bound to the top module below
`timescale 1ns/100ps
module egress_sel_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // bus and transmit path
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic half_width_state,
  input wire logic link_retry,
  input wire logic flit_bypassed,
  input wire logic [6:0] buffer_fill
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // any request, and no reason to hold flits back
  wire req = avs_read | avs_write;
  wire calm = !half_width_state && !link_retry;
  a_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("wait low for more than one cycle");
  a_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_idle: assert property (!req |-> avs_waitrequest)
    else $error("answer without request");
  a_rdata_hold: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
    else $error("read data moved outside an answer");
  a_fill_cap: assert property (buffer_fill <= 7'h40)
    else $error("fill above cap");
  a_fill_step: assert property ({1'b0, buffer_fill} <= {1'b0, $past(buffer_fill)} + 8'h02)
    else $error("fill grew by more than two");
  a_fill_unused: assert property ($past(calm, 1) && $past(calm, 2) && $past(calm, 3)
    && $past(buffer_fill) == 7'h00 |-> buffer_fill == 7'h00)
    else $error("buffer used in full width without retry");
  a_bypass_full: assert property (flit_bypassed |-> !($past(half_width_state, 1)
    && $past(half_width_state, 2) && $past(half_width_state, 3)))
    else $error("bypass in half width");
endmodule
bind link_egress_event_selector egress_sel_properties u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .half_width_state(half_width_state), .link_retry(link_retry),
  .flit_bypassed(flit_bypassed), .buffer_fill(buffer_fill));

// ### bench/link_egress_event_selector_tb.sv
// testbench: register bus, credit event table, flit framing and buffer
// assumes the checker binds itself; reads are scored from a queue
`timescale 1ns/100ps
`include "egress_sel_defs.svh"
module link_egress_event_selector_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] xfer_valid = 2'b00;
  egress_sel_pkg::flit_class_t cls0 = egress_sel_pkg::fc_none;
  egress_sel_pkg::flit_class_t cls1 = egress_sel_pkg::fc_none;
  logic half = 1'b0;
  logic retry = 1'b0;
  logic drain = 1'b0;
  egress_sel_pkg::credit_pulse_t pulse = '0;
  egress_sel_pkg::credit_level_t level = '0;
  logic bypassed;
  logic [6:0] fill;
  // levels chosen so several selections exceed their per-cycle cap
  localparam egress_sel_pkg::credit_level_t LVL = '{5'h14, 5'h0F, 5'h05, 5'h09, 4'h3, 4'h7,
    3'h7, 4'h3, 4'h2, 4'h4, 2'h1, 2'h1, 2'h2, 2'h3, 8'hC8};
  // code, unit mask, increment per cycle; last row runs without extended select
  logic [23:0] tbl [24] = '{24'h22_031C, 24'h22_020F, 24'h23_0105, 24'h23_030E,
    24'h24_0207, 24'h24_0308, 24'h25_0006, 24'h1F_0708, 24'h1F_0404, 24'h20_0302,
    24'h21_0202, 24'h1B_0080, 24'h26_0301, 24'h26_0000, 24'h28_0201, 24'h27_0101,
    24'h29_0001, 24'h2A_0401, 24'h2B_0101, 24'h2C_0201, 24'h1C_0001, 24'h07_0000,
    24'h04_0000, 24'h22_0300};
  logic [31:0] exp_q [$];  // expected read data, oldest first
  logic [31:0] exp_v;
  logic [31:0] lfsr = 32'h0000_ba9c;
  logic [31:0] e;
  int c;
  int b;
  int error_cnt = 0;
  int n_checks = 0;
  int byp_cnt = 0;  // bypass pulses seen on the status pin
  always #2.5 ref_clk = ~ref_clk;
  link_egress_event_selector u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .xfer_valid(xfer_valid), .xfer_class_lane0(cls0),
    .xfer_class_lane1(cls1), .half_width_state(half), .link_retry(retry), .buffer_drain(drain),
    .credit_pulse(pulse), .credit_level(level), .flit_bypassed(bypassed), .buffer_fill(fill));
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one transfer, held until waitrequest is sampled low; bounded wait
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        finish_test();
      end
      @(posedge ref_clk);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);  // gap so a release and a new request never share a step
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // drive both lanes for n transfers of one class
  task automatic send(input int n, input egress_sel_pkg::flit_class_t k);
    cls0 <= k;
    cls1 <= k;
    xfer_valid <= 2'b11;
    repeat (n) @(posedge ref_clk);
    xfer_valid <= 2'b00;
    repeat (4) @(posedge ref_clk);
  endtask
  // scoreboard: every read answer takes the oldest note
  always @(posedge ref_clk) begin
    if (bypassed === 1'b1) byp_cnt++;
    if (avs_read && avs_waitrequest === 1'b0) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD_BEEF;
      n_checks++;
      if (avs_readdata !== exp_v) begin
        error_cnt++;
        $display("[ERR] t=%0t got %h exp %h", $time, avs_readdata, exp_v);
      end
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // reset values, unmapped, unaligned and read-only places
    rd(6'h00, 32'h0000_0000);
    rd(6'h3C, 32'h0000_0000);
    bus(1'b1, 6'h10, 32'hFFFF_FFFF);
    rd(6'h10, 32'h0000_0000);
    bus(1'b1, 6'h01, 32'h0040_0001);
    rd(6'h00, 32'h0000_0000);
    // credit table, counters in rotation; clear set in each control write
    for (int i = 0; i < 24; i++) begin
      c = i % 4;
      e = {8'h00, tbl[i]};
      bus(1'b1, 6'(c * 4), {9'h000, 1'b1, i != 23, 3'b000, 1'b1, 1'b0, e[15:8], e[23:16]});
      rd(6'(c * 4), {9'h000, 1'b1, i != 23, 5'h00, e[15:8], e[23:16]});
      level <= LVL;
      pulse <= '1;
      repeat (5) @(posedge ref_clk);
      level <= '0;
      pulse <= '0;
      repeat (3) @(posedge ref_clk);
      rd(6'(16 + c * 8), 32'(e[7:0]) * 5);
      rd(6'(20 + c * 8), 32'h0000_0000);
    end
    // random flit classes against random single mask bits, full width
    for (int k = 0; k < 6; k++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      c = (lfsr % 5) + 1;
      b = (lfsr >> 3) % 5;
      bus(1'b1, 6'h0C, {9'h000, 2'b11, 3'b000, 1'b1, 1'b0, 8'(1 << b), 8'h01});
      send(4, egress_sel_pkg::flit_class_t'(3'(c)));
      rd(6'h28, (c - 1 == b) ? 32'h0000_0002 : 32'h0000_0000);
    end
    // half width: four transfers are half a flit; buffer takes both flits
    bus(1'b1, 6'h00, 32'h0062_1F01);
    bus(1'b1, 6'h04, 32'h0062_0004);
    half <= 1'b1;
    send(4, egress_sel_pkg::fc_ncs);
    rd(6'h10, 32'h0000_0000);
    send(4, egress_sel_pkg::fc_ncs);
    rd(6'h10, 32'h0000_0002);
    rd(6'h18, 32'h0000_0001);
    rd(6'h30, 32'h0000_0282);
    // retry keeps the buffer in use while it drains
    half <= 1'b0;
    retry <= 1'b1;
    drain <= 1'b1;
    repeat (2) @(posedge ref_clk);
    drain <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(6'h30, 32'h0000_0300);
    retry <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(6'h30, 32'h0000_0000);
    // only the six full width sends may go straight to the link
    n_checks++;
    if (byp_cnt != 6) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, byp_cnt, 6);
    end
    finish_test();
  end
endmodule
